// ### pgtmr_pkg.sv
// Constants, register map and types of the dual programmable down timer
package pgtmr_pkg;

    // Clock and oscillator rates
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned SLOW_OSC_HZ = 32_768;
    localparam int unsigned FAST_OSC_HZ = 4_000_000;
    localparam int unsigned FILT_HZ     = 2_048;
    localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_OSC_HZ;
    localparam int unsigned FAST_DIV    = CLK_HZ / FAST_OSC_HZ;
    localparam int unsigned FILT_DIV    = SLOW_OSC_HZ / FILT_HZ;

    // Register indices; byte address is four times the index
    localparam int          ADDR_W        = 18;
    localparam logic [15:0] REG_T0_MODE   = 16'hffc0;
    localparam logic [15:0] REG_OUT_SRC   = 16'hffc1;
    localparam logic [15:0] REG_T0_CTL    = 16'hffc2;
    localparam logic [15:0] REG_T1_CTL    = 16'hffc3;
    localparam logic [15:0] REG_T0_RLD_LO = 16'hffc4;
    localparam logic [15:0] REG_T0_RLD_HI = 16'hffc5;
    localparam logic [15:0] REG_T1_RLD_LO = 16'hffc6;
    localparam logic [15:0] REG_T1_RLD_HI = 16'hffc7;
    localparam logic [15:0] REG_T0_CNT_LO = 16'hffc8;
    localparam logic [15:0] REG_T0_CNT_HI = 16'hffc9;
    localparam logic [15:0] REG_T1_CNT_LO = 16'hffca;
    localparam logic [15:0] REG_T1_CNT_HI = 16'hffcb;
    localparam logic [15:0] REG_IRQ_EN    = 16'hffe2;
    localparam logic [15:0] REG_IRQ_PEND  = 16'hfff2;

    // Field positions
    localparam int EDGE_BIT     = 0;
    localparam int FILT_BIT     = 1;
    localparam int EVENT_BIT    = 2;
    localparam int SRC_T0_BIT   = 0;
    localparam int SRC_T1_BIT   = 1;
    localparam int WAVE_EN_BIT  = 2;
    localparam int WAVE_SEL_BIT = 3;
    localparam int RUN_BIT      = 0;
    localparam int PRELOAD_BIT  = 1;
    localparam int DIV_LSB      = 2;

    // Reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // Prescaler terminal counts (ratio minus one) for codes 00..11
    localparam logic [7:0] PRE_TC_1   = 8'h00;
    localparam logic [7:0] PRE_TC_4   = 8'h03;
    localparam logic [7:0] PRE_TC_32  = 8'h1f;
    localparam logic [7:0] PRE_TC_256 = 8'hff;

    typedef struct packed {
        logic [1:0] div;
        logic       src;
        logic       run;
    } pgtmr_ctl_t;

endpackage

// ### pgtmr_top.sv
// Dual 8-bit programmable down timer with event counter, APB slave
`timescale 1ns/1ps
module pgtmr_top
#(
    parameter int unsigned SLOW_DIV = pgtmr_pkg::SLOW_DIV,
    parameter int unsigned FAST_DIV = pgtmr_pkg::FAST_DIV
)
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pgtmr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        event_input_pin,
    output logic                             shared_out_pin,
    output logic                             timer_wave,
    output logic                             serial_clk_out,
    output logic                             irq_t0_req,
    output logic                             irq_t1_req
);

    // Control state
    pgtmr_pkg::pgtmr_ctl_t ctl [2];
    logic       event_mode_sel;
    logic       glitch_filter_en;
    logic       count_edge_sel;
    logic       wave_source_sel;
    logic       wave_out_en;
    logic [7:0] reload_value [2];
    logic [7:0] count [2];
    logic [3:0] hi_hold [2];
    logic [1:0] run_act;
    logic [1:0] irq_enable;
    logic [1:0] irq_pending;
    logic       serial_half;

    // Time bases and event path
    logic [15:0] slow_cnt;
    logic [15:0] fast_cnt;
    logic [3:0]  filt_cnt;
    logic        slow_tick;
    logic        fast_tick;
    logic        filt_tick;
    logic        evt_s;
    logic        evt_filt;
    logic [1:0]  evt_wait;
    logic        evt_lvl;
    logic        evt_prev;
    logic        evt_edge;

    logic [7:0] pre_cnt [2];
    logic [7:0] pre_tc  [2];
    logic [1:0] src_tick;
    logic [1:0] pre_tick;
    logic [1:0] in_tick;
    logic [1:0] uf;
    logic [1:0] preload_wr;

    // Bus decode
    logic        acc;
    logic        wr;
    logic        rd;
    logic [15:0] idx;
    logic        hit;
    logic [3:0]  wd;

    assign acc = psel && penable;
    // Refused accesses must neither write nor fire read side effects
    assign wr  = acc && pwrite && hit;
    assign rd  = acc && !pwrite && hit;
    assign idx = paddr[pgtmr_pkg::ADDR_W-1:2];
    assign wd  = pwdata[3:0];

    always_comb
    begin
        hit = (paddr[1:0] == 2'b00) &&
              (((idx >= pgtmr_pkg::REG_T0_MODE) && (idx <= pgtmr_pkg::REG_T1_CNT_HI)) ||
               (idx == pgtmr_pkg::REG_IRQ_EN) || (idx == pgtmr_pkg::REG_IRQ_PEND));
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;

    // Oscillator ticks derived from pclk; one-cycle enables keep one clock domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slow_cnt <= 16'h0000;
            fast_cnt <= 16'h0000;
        end
        else
        begin
            slow_cnt <= slow_tick ? 16'h0000 : slow_cnt + 16'h0001;
            fast_cnt <= fast_tick ? 16'h0000 : fast_cnt + 16'h0001;
        end
    end
    assign slow_tick = (slow_cnt == 16'(SLOW_DIV - 1));
    assign fast_tick = (fast_cnt == 16'(FAST_DIV - 1));

    // 2048 Hz filter strobe taken from the slow oscillator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt_cnt <= 4'h0;
        else if (slow_tick)
            filt_cnt <= filt_cnt + 4'h1;
    end
    assign filt_tick = slow_tick && (filt_cnt == 4'(pgtmr_pkg::FILT_DIV - 1));

    // Noise rejecter: a change must survive two filter strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_s    <= 1'b0;
            evt_filt <= 1'b0;
            evt_wait <= 2'b00;
        end
        else
        begin
            evt_s <= event_input_pin;
            if (evt_s == evt_filt)
                evt_wait <= 2'b00;
            else if (filt_tick && evt_wait == 2'b01)
            begin
                evt_filt <= evt_s;
                evt_wait <= 2'b00;
            end
            else if (filt_tick)
                evt_wait <= evt_wait + 2'b01;
        end
    end

    assign evt_lvl = glitch_filter_en ? evt_filt : evt_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_prev <= 1'b0;
        else
            evt_prev <= evt_lvl;
    end
    assign evt_edge = count_edge_sel ? (evt_lvl && !evt_prev) : (!evt_lvl && evt_prev);

    // Prescalers and input clock selection
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            src_tick[i] = ctl[i].src ? fast_tick : slow_tick;
            case (ctl[i].div)
                2'b00:   pre_tc[i] = pgtmr_pkg::PRE_TC_1;
                2'b01:   pre_tc[i] = pgtmr_pkg::PRE_TC_4;
                2'b10:   pre_tc[i] = pgtmr_pkg::PRE_TC_32;
                default: pre_tc[i] = pgtmr_pkg::PRE_TC_256;
            endcase
            pre_tick[i]   = src_tick[i] && (pre_cnt[i] == pre_tc[i]);
            preload_wr[i] = wr && (idx == (i == 0 ? pgtmr_pkg::REG_T0_CTL : pgtmr_pkg::REG_T1_CTL))
                            && wd[pgtmr_pkg::PRELOAD_BIT];
        end
        // Event mode bypasses timer 0 prescaler entirely
        in_tick[0] = event_mode_sel ? evt_edge : pre_tick[0];
        in_tick[1] = pre_tick[1];
        for (int i = 0; i < 2; i++)
            uf[i] = in_tick[i] && run_act[i] && (count[i] == 8'h00) && !preload_wr[i];
    end

    // Prescaler runs while a start or stop is pending so the change can land
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_cnt[0] <= pgtmr_pkg::RST_BYTE;
            pre_cnt[1] <= pgtmr_pkg::RST_BYTE;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (preload_wr[i] || !(ctl[i].run || run_act[i]))
                    pre_cnt[i] <= pgtmr_pkg::RST_BYTE;
                else if (pre_tick[i])
                    pre_cnt[i] <= pgtmr_pkg::RST_BYTE;
                else if (src_tick[i])
                    pre_cnt[i] <= pre_cnt[i] + 8'h01;
            end
        end
    end

    // Actual run state follows the run bit only at an input clock tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_act <= 2'b00;
        else
        begin
            for (int i = 0; i < 2; i++)
                if (in_tick[i])
                    run_act[i] <= ctl[i].run;
        end
    end

    // Down counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count[0] <= pgtmr_pkg::RST_BYTE;
            count[1] <= pgtmr_pkg::RST_BYTE;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (preload_wr[i])
                    count[i] <= reload_value[i];
                else if (uf[i])
                    count[i] <= reload_value[i];
                else if (in_tick[i] && run_act[i])
                    count[i] <= count[i] - 8'h01;
            end
        end
    end

    // Register writes; count registers have no write path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_mode_sel   <= 1'b0;
            glitch_filter_en <= 1'b0;
            count_edge_sel   <= 1'b0;
            wave_source_sel  <= 1'b0;
            wave_out_en      <= 1'b0;
            ctl[0]           <= '0;
            ctl[1]           <= '0;
            reload_value[0]  <= pgtmr_pkg::RST_BYTE;
            reload_value[1]  <= pgtmr_pkg::RST_BYTE;
            irq_enable       <= 2'b00;
        end
        else if (wr)
        begin
            case (idx)
                pgtmr_pkg::REG_T0_MODE:
                begin
                    event_mode_sel   <= wd[pgtmr_pkg::EVENT_BIT];
                    glitch_filter_en <= wd[pgtmr_pkg::FILT_BIT];
                    count_edge_sel   <= wd[pgtmr_pkg::EDGE_BIT];
                end
                pgtmr_pkg::REG_OUT_SRC:
                begin
                    wave_source_sel <= wd[pgtmr_pkg::WAVE_SEL_BIT];
                    wave_out_en     <= wd[pgtmr_pkg::WAVE_EN_BIT];
                    ctl[0].src      <= wd[pgtmr_pkg::SRC_T0_BIT];
                    ctl[1].src      <= wd[pgtmr_pkg::SRC_T1_BIT];
                end
                pgtmr_pkg::REG_T0_CTL:
                begin
                    ctl[0].div <= wd[pgtmr_pkg::DIV_LSB +: 2];
                    ctl[0].run <= wd[pgtmr_pkg::RUN_BIT];
                end
                pgtmr_pkg::REG_T1_CTL:
                begin
                    ctl[1].div <= wd[pgtmr_pkg::DIV_LSB +: 2];
                    ctl[1].run <= wd[pgtmr_pkg::RUN_BIT];
                end
                pgtmr_pkg::REG_T0_RLD_LO: reload_value[0][3:0] <= wd;
                pgtmr_pkg::REG_T0_RLD_HI: reload_value[0][7:4] <= wd;
                pgtmr_pkg::REG_T1_RLD_LO: reload_value[1][3:0] <= wd;
                pgtmr_pkg::REG_T1_RLD_HI: reload_value[1][7:4] <= wd;
                pgtmr_pkg::REG_IRQ_EN:    irq_enable <= wd[1:0];
                default: ;
            endcase
        end
    end

    // Low nibble read freezes the high nibble for a coherent pair
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hi_hold[0] <= pgtmr_pkg::RST_NIBBLE;
            hi_hold[1] <= pgtmr_pkg::RST_NIBBLE;
        end
        else if (rd && idx == pgtmr_pkg::REG_T0_CNT_LO)
            hi_hold[0] <= count[0][7:4];
        else if (rd && idx == pgtmr_pkg::REG_T1_CNT_LO)
            hi_hold[1] <= count[1][7:4];
    end

    // Pending flags: an underflow in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_pending <= 2'b00;
        else if (wr && idx == pgtmr_pkg::REG_IRQ_PEND)
            irq_pending <= (irq_pending & ~wd[1:0]) | uf;
        else
            irq_pending <= irq_pending | uf;
    end

    assign irq_t0_req = irq_pending[0] && irq_enable[0];
    assign irq_t1_req = irq_pending[1] && irq_enable[1];

    // Wave and serial clock: halved underflow rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_wave  <= 1'b0;
            serial_half <= 1'b0;
        end
        else
        begin
            if (wave_source_sel ? uf[1] : uf[0])
                timer_wave <= !timer_wave;
            if (uf[1])
                serial_half <= !serial_half;
        end
    end

    assign serial_clk_out = serial_half && run_act[1];
    // Enable gates the wave directly, so toggling it may clip a half cycle
    assign shared_out_pin = wave_out_en ? timer_wave : 1'b1;

    // Read data; reserved bits read zero
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd)
        begin
            case (idx)
                pgtmr_pkg::REG_T0_MODE:
                    prdata[2:0] = {event_mode_sel, glitch_filter_en, count_edge_sel};
                pgtmr_pkg::REG_OUT_SRC:
                    prdata[3:0] = {wave_source_sel, wave_out_en, ctl[1].src, ctl[0].src};
                pgtmr_pkg::REG_T0_CTL:
                    prdata[3:0] = {ctl[0].div, 1'b0, ctl[0].run || run_act[0]};
                pgtmr_pkg::REG_T1_CTL:
                    prdata[3:0] = {ctl[1].div, 1'b0, ctl[1].run || run_act[1]};
                pgtmr_pkg::REG_T0_RLD_LO: prdata[3:0] = reload_value[0][3:0];
                pgtmr_pkg::REG_T0_RLD_HI: prdata[3:0] = reload_value[0][7:4];
                pgtmr_pkg::REG_T1_RLD_LO: prdata[3:0] = reload_value[1][3:0];
                pgtmr_pkg::REG_T1_RLD_HI: prdata[3:0] = reload_value[1][7:4];
                pgtmr_pkg::REG_T0_CNT_LO: prdata[3:0] = count[0][3:0];
                pgtmr_pkg::REG_T0_CNT_HI: prdata[3:0] = hi_hold[0];
                pgtmr_pkg::REG_T1_CNT_LO: prdata[3:0] = count[1][3:0];
                pgtmr_pkg::REG_T1_CNT_HI: prdata[3:0] = hi_hold[1];
                pgtmr_pkg::REG_IRQ_EN:    prdata[1:0] = irq_enable;
                pgtmr_pkg::REG_IRQ_PEND:  prdata[1:0] = irq_pending;
                default:                  prdata = 32'h0000_0000;
            endcase
        end
    end

    // Checks
    a_uf_reloads: assert property (@(posedge pclk) disable iff (!presetn)
        uf[1] |=> count[1] == $past(reload_value[1]))
        else $error("timer 1 did not reload on underflow");

    a_uf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        uf[0] |=> irq_pending[0])
        else $error("underflow did not set pending flag");

    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_enable[1] |-> !irq_t1_req)
        else $error("masked interrupt reached request");

    a_pin_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
        !wave_out_en |-> shared_out_pin)
        else $error("shared pin not high while wave disabled");

    a_wave_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        (!wave_source_sel && uf[0]) |=> timer_wave != $past(timer_wave))
        else $error("wave did not toggle on selected underflow");

    a_wave_steady: assert property (@(posedge pclk) disable iff (!presetn)
        !uf[0] && !uf[1] |=> $stable(timer_wave))
        else $error("wave changed without underflow");

    a_preload: assert property (@(posedge pclk) disable iff (!presetn)
        preload_wr[0] |=> count[0] == $past(reload_value[0]))
        else $error("preload did not load counter");

    a_stopped_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_act[1] && !preload_wr[1]) |=> $stable(count[1]))
        else $error("stopped counter changed");

    a_run_change: assert property (@(posedge pclk) disable iff (!presetn)
        !in_tick[0] |=> $stable(run_act[0]))
        else $error("run state changed between input ticks");

    a_hi_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && idx == pgtmr_pkg::REG_T1_CNT_LO) |=> hi_hold[1] == $past(count[1][7:4]))
        else $error("high nibble not latched on low read");

endmodule

// ### pgtmr_evt_src.sv
// Behavioural source of pulses on the timer's external event pin
`timescale 1ns/1ps
module pgtmr_evt_src
(
    input  wire logic pclk,
    output logic      event_input_pin
);
    // Pin idles low and moves only just after a rising edge, as a synchronous source would
    initial event_input_pin = 1'b0;

    task automatic drive(input logic lvl, input int hold);
        @(posedge pclk);
        event_input_pin <= lvl;
        repeat (hold) @(posedge pclk);
    endtask

    task automatic pulse(input int w);
        drive(1'b1, w);
        drive(1'b0, w);
    endtask
endmodule

// ### pgtmr_tb_top.sv
// Self-checking testbench of the dual programmable down timer
`timescale 1ns/1ps
module pgtmr_tb_top;
    // Short oscillator divides keep the long prescaler ratios cheap to run
    localparam int S = 8;
    localparam int F = 2;
    logic                          pclk;
    logic                          presetn;
    logic                          psel;
    logic                          penable;
    logic                          pwrite;
    logic [pgtmr_pkg::ADDR_W-1:0]  paddr;
    logic [31:0]                   pwdata;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          event_input_pin;
    logic                          shared_out_pin;
    logic                          timer_wave;
    logic                          serial_clk_out;
    logic                          irq_t0_req;
    logic                          irq_t1_req;
    logic [31:0]                   rd;
    logic [7:0]                    v;
    logic                          sc;
    int                            error_cnt;
    int                            tests_run;
    int                            rat[4] = '{1, 4, 32, 256};

    pgtmr_top #(.SLOW_DIV(S), .FAST_DIV(F)) i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .event_input_pin(event_input_pin),
        .shared_out_pin(shared_out_pin), .timer_wave(timer_wave),
        .serial_clk_out(serial_clk_out), .irq_t0_req(irq_t0_req), .irq_t1_req(irq_t1_req)
    );

    pgtmr_evt_src i_src (.pclk(pclk), .event_input_pin(event_input_pin));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Idle cycle before each setup so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [3:0] wd,
                       input logic err);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= {28'h0000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(pslverr, err, "slave error");
        if (n >= 20)
        begin
            error_cnt++;
            $display("ERROR %0t: bus wait timed out", $time);
            end_of_test();
        end
        @(negedge pclk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [3:0] d);
        apb(1'b1, idx, d, 1'b0);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [3:0] e);
        apb(1'b0, idx, 4'h0, 1'b0);
        chk(rd, {28'h0000000, e}, $sformatf("register %h", idx));
    endtask

    // Low nibble first: that read freezes the high nibble
    task automatic cnt(input logic [15:0] lo, input logic [7:0] e);
        apb(1'b0, lo, 4'h0, 1'b0);
        v[3:0] = rd[3:0];
        apb(1'b0, lo + 16'h0001, 4'h0, 1'b0);
        v[7:4] = rd[3:0];
        chk(v, e, "count");
    endtask

    // First loop syncs to a toggle, second measures one full half period
    task automatic period(input int exp);
        int n;
        logic w;
        for (int k = 0; k < 2; k++)
        begin
            w = timer_wave;
            n = 0;
            while (timer_wave === w && n < 9000)
            begin
                @(negedge pclk);
                n++;
            end
        end
        chk(n, exp, "wave half period");
        if (n >= 9000)
            end_of_test();
        @(negedge pclk);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        error_cnt = 0;
        tests_run = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++)
            rdc(pgtmr_pkg::REG_T0_MODE + 16'(i), 4'h0);
        rdc(pgtmr_pkg::REG_IRQ_EN, 4'h0);
        rdc(pgtmr_pkg::REG_IRQ_PEND, 4'h0);
        apb(1'b0, 16'hffd0, 4'h0, 1'b1);
        $display("Test reset values done");
        // Event mode, falling edges; fast source and /256 set on purpose
        wr(pgtmr_pkg::REG_T0_MODE, 4'h4);
        wr(pgtmr_pkg::REG_OUT_SRC, 4'h1);
        wr(pgtmr_pkg::REG_T0_RLD_HI, 4'h1);
        wr(pgtmr_pkg::REG_T0_CTL, 4'hf);
        // First counted edge only starts the timer, so no decrement yet
        i_src.pulse(10);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h10);
        i_src.drive(1'b1, 600);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h10);
        i_src.drive(1'b0, 10);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h0f);
        wr(pgtmr_pkg::REG_T0_MODE, 4'h5);
        i_src.drive(1'b1, 10);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h0e);
        wr(pgtmr_pkg::REG_T0_CTL, 4'h0);
        i_src.drive(1'b0, 10);
        rdc(pgtmr_pkg::REG_T0_CTL, 4'h1);
        i_src.drive(1'b1, 10);
        rdc(pgtmr_pkg::REG_T0_CTL, 4'h0);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h0d);
        i_src.drive(1'b0, 10);
        i_src.drive(1'b1, 10);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h0d);
        wr(pgtmr_pkg::REG_T0_CTL, 4'h2);
        wr(pgtmr_pkg::REG_T0_CNT_LO, 4'h5);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h10);
        rdc(pgtmr_pkg::REG_T0_CTL, 4'h0);
        $display("Test event counter done");
        wr(pgtmr_pkg::REG_T0_MODE, 4'h6);
        wr(pgtmr_pkg::REG_T0_CTL, 4'h1);
        i_src.drive(1'b0, 300);
        i_src.pulse(300);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h0f);
        i_src.pulse(60);
        i_src.pulse(300);
        cnt(pgtmr_pkg::REG_T0_CNT_LO, 8'h0e);
        $display("Test noise filter done");
        wr(pgtmr_pkg::REG_T0_MODE, 4'h0);
        wr(pgtmr_pkg::REG_T0_RLD_HI, 4'h0);
        wr(pgtmr_pkg::REG_T1_RLD_LO, 4'h1);
        wr(pgtmr_pkg::REG_OUT_SRC, 4'hc);
        wr(pgtmr_pkg::REG_T0_CTL, 4'h3);
        for (int c = 0; c < 4; c++)
        begin
            wr(pgtmr_pkg::REG_T1_CTL, {2'(c), 2'b11});
            period(2 * rat[c] * S);
        end
        chk(shared_out_pin, timer_wave, "shared pin");
        wr(pgtmr_pkg::REG_OUT_SRC, 4'h6);
        period(S);
        wr(pgtmr_pkg::REG_T1_CTL, 4'h7);
        wr(pgtmr_pkg::REG_OUT_SRC, 4'he);
        period(2 * 4 * F);
        // Timer 1 underflows every 16 cycles here, so the serial clock flips once
        sc = serial_clk_out;
        repeat (2 * 4 * F) @(negedge pclk);
        chk(serial_clk_out, !sc, "serial clock running");
        wr(pgtmr_pkg::REG_OUT_SRC, 4'ha);
        chk(shared_out_pin, 1'b1, "shared pin idle");
        $display("Test prescaler and wave done");
        rdc(pgtmr_pkg::REG_IRQ_PEND, 4'h3);
        chk(irq_t0_req, 1'b0, "masked request");
        wr(pgtmr_pkg::REG_IRQ_EN, 4'h1);
        chk(irq_t0_req, 1'b1, "request 0");
        chk(irq_t1_req, 1'b0, "request 1");
        wr(pgtmr_pkg::REG_T0_CTL, 4'h0);
        wr(pgtmr_pkg::REG_T1_CTL, 4'h0);
        repeat (300) @(posedge pclk);
        wr(pgtmr_pkg::REG_IRQ_PEND, 4'h0);
        rdc(pgtmr_pkg::REG_IRQ_PEND, 4'h3);
        wr(pgtmr_pkg::REG_IRQ_PEND, 4'h1);
        rdc(pgtmr_pkg::REG_IRQ_PEND, 4'h2);
        chk(irq_t0_req, 1'b0, "cleared request");
        wr(pgtmr_pkg::REG_IRQ_EN, 4'hf);
        rdc(pgtmr_pkg::REG_IRQ_EN, 4'h3);
        chk(irq_t1_req, 1'b1, "request 1");
        wr(pgtmr_pkg::REG_IRQ_PEND, 4'h2);
        rdc(pgtmr_pkg::REG_IRQ_PEND, 4'h0);
        chk(serial_clk_out, 1'b0, "serial clock stopped");
        $display("Test interrupts done");
        end_of_test();
    end
endmodule
